// >>> dv/aom_cmd_handler_tb_top.sv
/*
  Self-checking bench for the command handler: mailbox commands over APB,
  notice gating, slot plugging and output area stop actions.
  Assumes the host model owns APB; reads are scored from a queue.
*/
module aom_cmd_handler_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import aom_pkg::*;

  localparam int OW = 32;
  logic clock, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic ctrlRun, recordIsIdent, plugReq, plugAccept, plugReject, r;
  logic [6:0] evt;
  logic [10:0] notice;
  logic [15:0] plugSlot, s, e1;
  logic [OW-1:0] appOutData, outArea, v;
  logic [32:0] expQ [$];
  integer seed;
  int nMismatch, nCompared;
  logic [5:0] en;
  logic [15:0] slots;
  logic [1:0] act;
  logic adv;

  // ==========================================================
  // Design, host and clock
  aom_cmd_handler #(.OUT_W(OW)) aom_cmd_handler_inst (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ctrlRun(ctrlRun),
    .cfgMismatchEvt(evt[6]), .prmDoneEvt(evt[5]), .alarmAckEvt(evt[4]),
    .connUpEvt(evt[3]), .connDownEvt(evt[2]), .recordReadEvt(evt[1]),
    .recordWriteEvt(evt[0]), .recordIsIdent(recordIsIdent),
    .plugReq(plugReq), .plugSlot(plugSlot), .plugAccept(plugAccept),
    .plugReject(plugReject), .configMismatchNotice(notice[10]),
    .paramDoneNotice(notice[9]), .alarmAckNotice(notice[8]),
    .connectionCheckNotice(notice[7]), .connectionInfoNotice(notice[6]),
    .connectionAbortNotice(notice[5]),
    .connectionOfflineNotice(notice[4]), .recordReadNotice(notice[3]),
    .recordWriteNotice(notice[2]), .paramAreaAccess(notice[1]),
    .identInternal(notice[0]), .appOutData(appOutData),
    .outArea(outArea));

  aom_host_model host (
    .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // Free-running 50 ns clock.
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ==========================================================
  // Checking
  task automatic chk(input logic [32:0] got, exp);
    nCompared++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Every completed read takes the oldest expectation; an empty queue
  // yields a value that cannot match, so a surplus read is caught.
  always @(posedge clock)
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0)
      chk({pslverr, prdata}, expQ.size() ? expQ.pop_front() : '1);

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    logic [31:0] x;
    logic f;
    expQ.push_back(e);
    host.xfer(1'b0, a, 32'h0000_0000, x, f);
  endtask : rd

  function automatic logic [32:0] stat(input logic valid);
    return {1'b0, slots, 2'b00, en, 3'b000, act, adv, ctrlRun, valid};
  endfunction : stat

  // Command plus full response readback; the model follows only
  // commands that are expected to be accepted.
  task automatic run_cmd(input logic [15:0] info, num, size, x1, x2, flt);
    host.command(info, num, size, x1, x2);
    rd(REG_RSP_INFO, {17'h0, MSG_INFO_RSP});
    rd(REG_RSP_NUM, {17'h0, num});
    rd(REG_RSP_EXT1, {17'h0, x1});
    rd(REG_RSP_EXT2, {17'h0, x2});
    rd(REG_RSP_FAULT, {17'h0, flt});
    if (flt == FLT_NONE && num == ADV_OP_CMD)
    begin
      en = x1[5:0];
      slots = x2;
      adv = 1'b1;
    end
    if (flt == FLT_NONE && num == STOP_ACT_CMD)
      act = x1[1:0];
    rd(REG_STATUS, stat(1'b1));
  endtask : run_cmd

  // Each network event once, alone, with a random ident qualifier.
  task automatic events();
    logic [6:0] ev;
    logic [10:0] e;
    logic id, g, rec;
    for (int i = 0; i < 7; i++)
    begin
      ev = 7'h01 << i;
      id = 1'($random(seed));
      g = id ? en[5] : en[1];
      rec = ev[1] | ev[0];
      e = {ev[6] & en[0], ev[5] & en[2], ev[4] & en[3], {2{ev[3] & en[4]}},
        {2{ev[2] & en[4]}}, ev[1] & g, ev[0] & g, rec & !g & !id,
        rec & !g & id};
      @(posedge clock);
      evt <= ev;
      recordIsIdent <= id;
      @(posedge clock);
      evt <= 7'h00;
      @(posedge clock);
      chk({22'h0, notice}, {22'h0, e});
    end
  endtask : events

  task automatic plug(input logic [15:0] slot);
    @(posedge clock);
    plugReq <= 1'b1;
    plugSlot <= slot;
    @(posedge clock);
    plugReq <= 1'b0;
    @(posedge clock);
    chk({31'h0, plugAccept, plugReject},
      {31'h0, slot < slots, slot >= slots});
  endtask : plug

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Scenarios
  initial
  begin
    seed = 26094;
    {nrst, ctrlRun, recordIsIdent, plugReq, plugSlot, evt} = '0;
    appOutData = '0;
    {en, act, adv} = '0;
    slots = SLOT_RESET;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    rd(REG_STATUS, stat(1'b0));
    events();
    plug(16'h003F);
    plug(16'h0040);
    rd(8'h34, {1'b1, 32'h0});
    rd(8'h02, {1'b1, 32'h0});
    host.xfer(1'b1, 8'h34, 32'h0000_0001, d, r);
    chk({32'h0, r}, 33'h1);
    run_cmd(MSG_INFO_CMD, ADV_OP_CMD, DATA_SIZE_NONE, 16'h003F, 16'h0010,
      FLT_PHASE);
    host.xfer(1'b1, REG_CTRL, 32'h0000_0001, d, r);
    run_cmd(16'h4003, ADV_OP_CMD, DATA_SIZE_NONE, 16'h0001, 16'h0010,
      FLT_FRAME);
    run_cmd(MSG_INFO_CMD, ADV_OP_CMD, 16'h0002, 16'h0001, 16'h0010,
      FLT_FRAME);
    run_cmd(MSG_INFO_CMD, ADV_OP_CMD, DATA_SIZE_NONE, 16'h0001, 16'h0000,
      FLT_SLOT);
    run_cmd(MSG_INFO_CMD, ADV_OP_CMD, DATA_SIZE_NONE, 16'h0001, 16'h0041,
      FLT_SLOT);
    run_cmd(MSG_INFO_CMD, ADV_OP_CMD, DATA_SIZE_NONE, 16'h0040, 16'h0010,
      FLT_RESERVED);
    // Random enables and slot limits, the lowest limit first.
    for (int k = 0; k < 4; k++)
    begin
      v = $random(seed);
      s = k == 0 ? SLOT_MIN : 16'(v[21:16]) + 16'h0001;
      e1 = {10'h000, v[5:0]};
      run_cmd(MSG_INFO_CMD, ADV_OP_CMD, DATA_SIZE_NONE, e1, s,
        FLT_NONE);
      events();
      plug(16'h0000);
      plug(s - 16'h0001);
      plug(s);
      run_cmd(MSG_INFO_CMD, IDENT_SET_CMD, DATA_SIZE_NONE, 16'h0000,
        16'h0000, en[5] ? FLT_NONE : FLT_FRAME);
    end
    host.xfer(1'b1, REG_STATUS, 32'h0000_0001, d, r);
    rd(REG_STATUS, stat(1'b0));
    // Every stop action, then an undefined code that must keep the last.
    for (int c = 0; c < 4; c++)
    begin
      run_cmd(MSG_INFO_CMD, STOP_ACT_CMD, DATA_SIZE_NONE, 16'(c), 16'h0000,
        c < 3 ? FLT_NONE : FLT_ACTION);
      v = $random(seed);
      @(posedge clock);
      ctrlRun <= 1'b1;
      appOutData <= v;
      repeat (3) @(posedge clock);
      chk({1'b0, outArea}, {1'b0, v});
      ctrlRun <= 1'b0;
      appOutData <= ~v;
      repeat (3) @(posedge clock);
      chk({1'b0, outArea}, {1'b0, act == 2'b00 ? {OW{1'b0}} :
        act == 2'b01 ? v : {OW{1'b1}}});
    end
    give_verdict();
  end

  // A hang ends the run through the same verdict.
  initial
  begin
    #2000000;
    nMismatch++;
    give_verdict();
  end
endmodule : aom_cmd_handler_tb_top

// >>> dv/aom_host_model.sv
/*
  Host-side APB master model for the command handler: single transfers
  and whole mailbox commands.
  Assumes a slave that raises pready for one cycle per access.
*/
module aom_host_model (
  // Clock
  input wire logic clock,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  import aom_pkg::*;

  // Idle bus from time zero so the slave never sees a stray request.
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // ==========================================================
  // Transfers
  // The request is held until pready is sampled high at a rising edge.
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Header words, extended words, then the go strobe, in that order.
  task automatic command(input logic [15:0] info, num, size, e1, e2);
    logic [15:0] w [5];
    logic [31:0] rd;
    logic err;
    w = '{info, num, size, e1, e2};
    for (int i = 0; i < 5; i++)
      xfer(1'b1, REG_CMD_INFO + 8'(4 * i), {16'h0000, w[i]}, rd, err);
    xfer(1'b1, REG_CMD_GO, 32'h0000_0001, rd, err);
  endtask : command
endmodule : aom_host_model

// >>> rtl/aom_cmd_handler.sv
/*
  Command handler for the advanced-operation and stop-output-action mailbox
  commands, with the notice gating and output area control they steer.
  Assumes an APB master on one side and network-side event pulses, all
  synchronous to clock; nrst is asynchronous and active low.
*/
// The placing of the registers and register access over APB were chosen for this implementation.
// Operation
// - Answer advanced command, echo words, fault
// - Bit 0 gates configuration mismatch notice
// - Bit 1 forwards records, else parameter areas
// - Bit 2 gates parameterization done notice
// - Bit 3 gates alarm acknowledge notice
// - Bit 4 gates connection indication notices
// - Bit 5 forwards ident requests, else internal
// - Slot limit 1 to 64, default 64
// - Plugging allowed only below slot limit
// - Apply stop action on RUN to STOP
// - Stop action echoed in word one, fault
// - Codes: clear default, freeze, set ones
module aom_cmd_handler
#(
  parameter int OUT_W = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Network controller events
  input wire logic ctrlRun,
  input wire logic cfgMismatchEvt,
  input wire logic prmDoneEvt,
  input wire logic alarmAckEvt,
  input wire logic connUpEvt,
  input wire logic connDownEvt,
  input wire logic recordReadEvt,
  input wire logic recordWriteEvt,
  input wire logic recordIsIdent,
  // Slot plugging requests
  input wire logic plugReq,
  input wire logic [15:0] plugSlot,
  output logic plugAccept,
  output logic plugReject,
  // Notices to the host mailbox
  output logic configMismatchNotice,
  output logic paramDoneNotice,
  output logic alarmAckNotice,
  output logic connectionCheckNotice,
  output logic connectionInfoNotice,
  output logic connectionAbortNotice,
  output logic connectionOfflineNotice,
  output logic recordReadNotice,
  output logic recordWriteNotice,
  output logic paramAreaAccess,
  output logic identInternal,
  // Output data area
  input wire logic [OUT_W-1:0] appOutData,
  output logic [OUT_W-1:0] outArea
);
  import aom_pkg::*;

  // ==========================================================
  // Declarations
  logic [15:0] cmdInfo_ff, cmdNum_ff, cmdSize_ff, cmdExt1_ff, cmdExt2_ff;
  logic [15:0] rspInfo_ff, rspNum_ff, rspExt1_ff, rspExt2_ff, rspFault_ff;
  logic rspValid_ff, goPulse_ff, initPhase_ff, advMode_ff, runPrev_ff;
  logic [15:0] enables_ff, slotLimit_ff, nxt_fault;
  aom_action_t action_ff;
  logic [EN_USED-1:0] noticeGate;
  logic [31:0] prdata_ff, nxt_rdata;
  logic pready_ff, pslverr_ff, nxt_mapped;
  logic apbAcc, apbWr, apbRd, stopEdge, fwdRecord;
  logic [10:0] notice_ff;
  logic plugAccept_ff, plugReject_ff;
  logic [OUT_W-1:0] outArea_ff;

  // Decoding shared by write strobe and error answer.
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a <= REG_CTRL) && (a[1:0] == 2'b00);
  endfunction : isMapped

  // ==========================================================
  // APB slave: one wait state; a write lands at the edge pready is seen.
  assign apbAcc = psel && penable && !pready_ff;
  assign apbWr = psel && penable && pready_ff && pwrite && isMapped(paddr);
  assign apbRd = apbAcc && !pwrite;

  // Read data mux; unmapped reads return zero with an error.
  always_comb
  begin
    nxt_mapped = isMapped(paddr);
    case (paddr)
      REG_CMD_INFO: nxt_rdata = {16'h0000, cmdInfo_ff};
      REG_CMD_NUM: nxt_rdata = {16'h0000, cmdNum_ff};
      REG_CMD_SIZE: nxt_rdata = {16'h0000, cmdSize_ff};
      REG_CMD_EXT1: nxt_rdata = {16'h0000, cmdExt1_ff};
      REG_CMD_EXT2: nxt_rdata = {16'h0000, cmdExt2_ff};
      REG_RSP_INFO: nxt_rdata = {16'h0000, rspInfo_ff};
      REG_RSP_NUM: nxt_rdata = {16'h0000, rspNum_ff};
      REG_RSP_EXT1: nxt_rdata = {16'h0000, rspExt1_ff};
      REG_RSP_EXT2: nxt_rdata = {16'h0000, rspExt2_ff};
      REG_RSP_FAULT: nxt_rdata = {16'h0000, rspFault_ff};
      REG_STATUS: nxt_rdata = {slotLimit_ff, enables_ff[7:0], 3'b000,
                               action_ff, advMode_ff, runPrev_ff,
                               rspValid_ff};
      REG_CTRL: nxt_rdata = {31'h00000000, initPhase_ff};
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // Bus handshake registers; pready is a single-cycle pulse.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      {pready_ff, pslverr_ff, prdata_ff} <= 34'h000000000;
    else
    begin
      pready_ff <= apbAcc;
      pslverr_ff <= apbAcc && !nxt_mapped;
      prdata_ff <= apbRd ? nxt_rdata : 32'h00000000;
    end
  end

  // Command staging words and the doorbell strobe.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      {cmdInfo_ff, cmdNum_ff, cmdSize_ff, cmdExt1_ff, cmdExt2_ff, goPulse_ff}
        <= 81'h0;
    else
    begin
      goPulse_ff <= apbWr && (paddr == REG_CMD_GO);
      if (apbWr && paddr == REG_CMD_INFO) cmdInfo_ff <= pwdata[15:0];
      if (apbWr && paddr == REG_CMD_NUM) cmdNum_ff <= pwdata[15:0];
      if (apbWr && paddr == REG_CMD_SIZE) cmdSize_ff <= pwdata[15:0];
      if (apbWr && paddr == REG_CMD_EXT1) cmdExt1_ff <= pwdata[15:0];
      if (apbWr && paddr == REG_CMD_EXT2) cmdExt2_ff <= pwdata[15:0];
    end
  end

  // Init phase flag; software sets it after generic init, clears at run.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      initPhase_ff <= 1'b0;
    else if (apbWr && paddr == REG_CTRL)
      initPhase_ff <= pwdata[0];
  end

  // ==========================================================
  // Command check. Header must be a single-frame command with no data.
  always_comb
  begin
    nxt_fault = FLT_NONE;
    if (cmdInfo_ff != MSG_INFO_CMD || cmdSize_ff != DATA_SIZE_NONE)
      nxt_fault = FLT_FRAME;
    else if (cmdNum_ff == ADV_OP_CMD)
    begin
      if (!initPhase_ff)
        nxt_fault = FLT_PHASE;
      else if (cmdExt1_ff[15:EN_USED] != '0)
        nxt_fault = FLT_RESERVED;
      else if (cmdExt2_ff < SLOT_MIN || cmdExt2_ff > SLOT_MAX)
        nxt_fault = FLT_SLOT;
    end
    else if (cmdNum_ff == STOP_ACT_CMD)
    begin
      if (!initPhase_ff)
        nxt_fault = FLT_PHASE;
      else if (cmdExt1_ff > 16'h0002)
        nxt_fault = FLT_ACTION;
    end
    else if (cmdNum_ff == IDENT_SET_CMD)
    begin
      if (!(advMode_ff && enables_ff[EN_IDENT]))
        nxt_fault = FLT_FRAME;
    end
    else
      nxt_fault = FLT_FRAME;
  end

  // Response words. Valid flag: a new answer wins over a clear.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      {rspInfo_ff, rspNum_ff, rspExt1_ff, rspExt2_ff, rspFault_ff,
        rspValid_ff} <= 81'h0;
    else if (goPulse_ff)
    begin
      rspInfo_ff <= MSG_INFO_RSP;
      rspNum_ff <= cmdNum_ff;
      rspExt1_ff <= cmdExt1_ff;
      rspExt2_ff <= cmdExt2_ff;
      rspFault_ff <= nxt_fault;
      rspValid_ff <= 1'b1;
    end
    else if (apbWr && paddr == REG_STATUS && pwdata[0])
      rspValid_ff <= 1'b0;
  end

  // Mode settings taken only from an accepted command.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      advMode_ff <= 1'b0;
      enables_ff <= 16'h0000;
      slotLimit_ff <= SLOT_RESET;
      action_ff <= AOM_ACT_CLEAR;
    end
    else if (goPulse_ff && nxt_fault == FLT_NONE)
    begin
      if (cmdNum_ff == ADV_OP_CMD)
      begin
        advMode_ff <= 1'b1;
        enables_ff <= cmdExt1_ff;
        slotLimit_ff <= cmdExt2_ff;
      end
      if (cmdNum_ff == STOP_ACT_CMD)
        action_ff <= aom_action_t'(cmdExt1_ff[1:0]);
    end
  end

  // ==========================================================
  // Notice gating. Enables count only once advanced mode is on.
  assign noticeGate = advMode_ff ? enables_ff[EN_USED-1:0] : '0;
  assign fwdRecord = recordIsIdent ? noticeGate[EN_IDENT]
                                   : noticeGate[EN_RECORD];
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      notice_ff <= 11'h000;
    else
    begin
      notice_ff[0] <= cfgMismatchEvt && noticeGate[EN_MISMATCH];
      notice_ff[1] <= prmDoneEvt && noticeGate[EN_PRM_DONE];
      notice_ff[2] <= alarmAckEvt && noticeGate[EN_ALARM_ACK];
      notice_ff[4:3] <= {2{connUpEvt && noticeGate[EN_CONN]}};
      notice_ff[6:5] <= {2{connDownEvt && noticeGate[EN_CONN]}};
      notice_ff[7] <= recordReadEvt && fwdRecord;
      notice_ff[8] <= recordWriteEvt && fwdRecord;
      notice_ff[9] <= (recordReadEvt || recordWriteEvt) && !recordIsIdent
                      && !fwdRecord;
      notice_ff[10] <= (recordReadEvt || recordWriteEvt) && recordIsIdent
                       && !fwdRecord;
    end
  end

  // ==========================================================
  // Slot admission; a limit of N admits slots 0 to N-1.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      {plugAccept_ff, plugReject_ff} <= 2'h0;
    else
    begin
      plugAccept_ff <= plugReq && (plugSlot < slotLimit_ff);
      plugReject_ff <= plugReq && (plugSlot >= slotLimit_ff);
    end
  end

  // ==========================================================
  // Output area. Follows the application while running; on the RUN to
  // STOP step the chosen action applies and then holds until RUN again.
  assign stopEdge = runPrev_ff && !ctrlRun;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      runPrev_ff <= 1'b0;
      outArea_ff <= '0;
    end
    else
    begin
      runPrev_ff <= ctrlRun;
      if (ctrlRun)
        outArea_ff <= appOutData;
      else if (stopEdge)
      begin
        case (action_ff)
          AOM_ACT_CLEAR: outArea_ff <= '0;
          AOM_ACT_FREEZE: outArea_ff <= outArea_ff;
          AOM_ACT_SET: outArea_ff <= '1;
          default: outArea_ff <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Output wiring, all from flip-flops.
  assign {prdata, pready, pslverr} = {prdata_ff, pready_ff, pslverr_ff};
  assign {identInternal, paramAreaAccess, recordWriteNotice, recordReadNotice,
    connectionOfflineNotice, connectionAbortNotice, connectionInfoNotice,
    connectionCheckNotice, alarmAckNotice, paramDoneNotice,
    configMismatchNotice} = notice_ff;
  assign {plugAccept, plugReject} = {plugAccept_ff, plugReject_ff};
  assign outArea = outArea_ff;

  // ==========================================================
  // Assertions guarding the command, notice, slot admission and output area stop behaviour.
  adv_rsp_info_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(rspValid_ff) |-> rspInfo_ff == MSG_INFO_RSP)
    else $error("response info word wrong");
  adv_echo_a: assert property (@(posedge clock) disable iff (!nrst)
    goPulse_ff |=> rspNum_ff == $past(cmdNum_ff)
                   && rspExt2_ff == $past(cmdExt2_ff))
    else $error("response does not echo command");
  mismatch_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    cfgMismatchEvt && advMode_ff && enables_ff[EN_MISMATCH] |=>
      configMismatchNotice)
    else $error("mismatch notice missing");
  mismatch_quiet_a: assert property (@(posedge clock) disable iff (!nrst)
    configMismatchNotice |-> $past(enables_ff[EN_MISMATCH]))
    else $error("mismatch notice while disabled");
  record_route_a: assert property (@(posedge clock) disable iff (!nrst)
    !(recordReadNotice && paramAreaAccess))
    else $error("record routed two ways");
  prm_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    paramDoneNotice |-> $past(prmDoneEvt && enables_ff[EN_PRM_DONE]))
    else $error("param done notice wrong");
  alarm_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    alarmAckNotice |-> $past(alarmAckEvt && enables_ff[EN_ALARM_ACK]))
    else $error("alarm notice wrong");
  conn_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    connDownEvt && advMode_ff && enables_ff[EN_CONN] |=>
      connectionAbortNotice && connectionOfflineNotice)
    else $error("connection notices missing");
  slot_range_a: assert property (@(posedge clock) disable iff (!nrst)
    slotLimit_ff >= SLOT_MIN && slotLimit_ff <= SLOT_MAX)
    else $error("slot limit out of range");
  slot_admit_a: assert property (@(posedge clock) disable iff (!nrst)
    plugReq && plugSlot >= slotLimit_ff |=> plugReject && !plugAccept)
    else $error("slot above limit admitted");
  stop_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    stopEdge && action_ff == AOM_ACT_CLEAR |=> outArea == '0)
    else $error("output area not cleared on stop");
  stop_set_a: assert property (@(posedge clock) disable iff (!nrst)
    stopEdge && action_ff == AOM_ACT_SET |=> outArea == '1)
    else $error("output area not set on stop");
  bad_action_a: assert property (@(posedge clock) disable iff (!nrst)
    goPulse_ff && cmdNum_ff == STOP_ACT_CMD && cmdExt1_ff > 16'h0002
      && initPhase_ff && cmdInfo_ff == MSG_INFO_CMD
      && cmdSize_ff == DATA_SIZE_NONE |=> rspFault_ff == FLT_ACTION
      && $stable(action_ff))
    else $error("bad action code accepted");
  cmd_done_c: cover property (@(posedge clock) disable iff (!nrst)
    goPulse_ff && cmdNum_ff == ADV_OP_CMD ##1 rspFault_ff == FLT_NONE);
  stop_freeze_c: cover property (@(posedge clock) disable iff (!nrst)
    stopEdge && action_ff == AOM_ACT_FREEZE);
  record_fwd_c: cover property (@(posedge clock) disable iff (!nrst)
    recordWriteNotice);
endmodule : aom_cmd_handler

// >>> rtl/aom_pkg.sv
/*
  Shared constants for the advanced-operation and stop-action command
  handler: mailbox word values, register map, field positions, fault codes.
  Assumes a 32-bit APB master and a single 20 MHz clock domain.
*/
package aom_pkg;
  // ==========================================================
  // Mailbox header values
  localparam logic [15:0] MSG_INFO_CMD = 16'h4002;
  localparam logic [15:0] MSG_INFO_RSP = 16'h0002;
  localparam logic [15:0] ADV_OP_CMD = 16'h0100;
  localparam logic [15:0] STOP_ACT_CMD = 16'h0101;
  localparam logic [15:0] IDENT_SET_CMD = 16'h0110;
  localparam logic [15:0] DATA_SIZE_NONE = 16'h0000;
  // ==========================================================
  // Notification enable bit positions
  localparam int EN_MISMATCH = 0;
  localparam int EN_RECORD = 1;
  localparam int EN_PRM_DONE = 2;
  localparam int EN_ALARM_ACK = 3;
  localparam int EN_CONN = 4;
  localparam int EN_IDENT = 5;
  localparam int EN_USED = 6;
  // ==========================================================
  // Slot limit and stop actions
  localparam logic [15:0] SLOT_MIN = 16'h0001;
  localparam logic [15:0] SLOT_MAX = 16'h0040;
  localparam logic [15:0] SLOT_RESET = 16'h0040;
  typedef enum logic [1:0] {
    AOM_ACT_CLEAR = 2'b00,
    AOM_ACT_FREEZE = 2'b01,
    AOM_ACT_SET = 2'b10
  } aom_action_t;
  // ==========================================================
  // Fault information codes
  localparam logic [15:0] FLT_NONE = 16'h0000;
  localparam logic [15:0] FLT_SLOT = 16'h0001;
  localparam logic [15:0] FLT_ACTION = 16'h0002;
  localparam logic [15:0] FLT_FRAME = 16'h0003;
  localparam logic [15:0] FLT_PHASE = 16'h0004;
  localparam logic [15:0] FLT_RESERVED = 16'h0005;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] REG_CMD_INFO = 8'h00;
  localparam logic [7:0] REG_CMD_NUM = 8'h04;
  localparam logic [7:0] REG_CMD_SIZE = 8'h08;
  localparam logic [7:0] REG_CMD_EXT1 = 8'h0C;
  localparam logic [7:0] REG_CMD_EXT2 = 8'h10;
  localparam logic [7:0] REG_CMD_GO = 8'h14;
  localparam logic [7:0] REG_RSP_INFO = 8'h18;
  localparam logic [7:0] REG_RSP_NUM = 8'h1C;
  localparam logic [7:0] REG_RSP_EXT1 = 8'h20;
  localparam logic [7:0] REG_RSP_EXT2 = 8'h24;
  localparam logic [7:0] REG_RSP_FAULT = 8'h28;
  localparam logic [7:0] REG_STATUS = 8'h2C;
  localparam logic [7:0] REG_CTRL = 8'h30;
endpackage : aom_pkg
